//--- pdl_defs.vh
`ifndef PDL_DEFS_VH
`define PDL_DEFS_VH
// register index map, one 8-bit register per address
`define PDL_ADDR_W 4
`define PDL_OFF_ENABLE_HIGH 4'h0
`define PDL_OFF_ENABLE_LOW 4'h1
`define PDL_OFF_LEVEL_HIGH 4'h2
`define PDL_OFF_LEVEL_LOW 4'h3
`define PDL_OFF_STAGED_HIGH 4'h4
`define PDL_OFF_STAGED_LOW 4'h5
`define PDL_OFF_TRIG_SELECT 4'h6
// trigger select field: two bits per group, group g at bits 2g+1:2g
`define PDL_TRIG_SEL_W 2
`define PDL_NUM_TRIG 4
`define PDL_NUM_GROUPS 4
`define PDL_GROUP_W 4
// reset values
`define PDL_RST_ENABLE 8'h00
`define PDL_RST_LEVEL 8'h00
`define PDL_RST_GROUP_LEVEL 4'h0
`define PDL_RST_STAGED 8'h00
`define PDL_RST_TRIG_SELECT 8'h00
`define PDL_UNMAPPED_READ 8'h00
`define PDL_RST_RDATA 8'h00
`endif

//--- pdl_group.v
`include "pdl_defs.vh"
// one four-bit output group: picks its trigger and updates enabled bits
module pdl_group (
  input wire core_clk,
  input wire rst,
  input wire [3:0] trig_pulse,
  input wire [1:0] trig_sel,
  input wire [3:0] enable,
  input wire [3:0] staged,
  input wire [3:0] cpu_wr_mask,
  input wire [3:0] cpu_wr_data,
  output wire [3:0] level
);
  reg [3:0] level_q;
  reg [3:0] level_d;
  wire fire;

  // selected trigger pulse for this group
  assign fire = trig_pulse[trig_sel];

  // trigger copies staged data for enabled bits; cpu writes only unenabled bits
  always @* begin
    level_d = level_q;
    if (fire) begin
      level_d = (level_q & ~enable) | (staged & enable); // [RL2] [RL3]
    end
    // enabled bits are locked against cpu writes, so no conflict with the trigger
    level_d = (level_d & ~(cpu_wr_mask & ~enable)) |
              (cpu_wr_data & cpu_wr_mask & ~enable); // [RL5] [RL6]
  end

  always @(posedge core_clk) begin
    if (rst) begin
      level_q <= `PDL_RST_GROUP_LEVEL;
    end else begin
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule

//--- pdl_top.v
// How it works
// (RL1) sixteen enable bits, high byte outputs 15..8, low byte 7..0
// (RL2) enabled bit takes staged bit when its selected trigger fires
// (RL3) disabled bit keeps its level on a trigger
// (RL4) sixteen-bit output level register in high and low bytes
// (RL5) cpu writes cannot change enabled output level bits; reads show them
// (RL6) cpu may write output level bits whose enable is clear
// (RL7) enable bits read/write individually and reset to zero
// (RL8) each group's trigger chosen by the trigger select register
// (RL9) outputs form four groups of four bits, each independent
// (RL10) output level bits drive the pulse pins directly
`include "pdl_defs.vh"
module pdl_top (
  input wire core_clk,
  input wire rst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  input wire [3:0] trig_pulse,
  output wire [15:0] pulse_out
);
  // byte registers as software sees them
  reg [7:0] next_enable_high_q;
  reg [7:0] next_enable_low_q;
  reg [7:0] staged_level_high_q;
  reg [7:0] staged_level_low_q;
  reg [7:0] trig_select_q;

  // their next values
  wire [7:0] next_enable_high_d;
  wire [7:0] next_enable_low_d;
  wire [7:0] staged_level_high_d;
  wire [7:0] staged_level_low_d;
  wire [7:0] trig_select_d;

  // read data flop and its next value
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;

  // sixteen-bit views handed to the four groups
  wire [15:0] pulse_bit_enable;
  wire [15:0] staged_level;
  wire [15:0] level;

  // cpu side of the output level register
  wire [15:0] cpu_wr_mask;
  wire [15:0] cpu_wr_data;

  // one decoded write strobe per register
  wire wr_enable_high;
  wire wr_enable_low;
  wire wr_level_high;
  wire wr_level_low;
  wire wr_staged_high;
  wire wr_staged_low;
  wire wr_trig_select;

  // write decode shared by registers and the level write mask
  function wr_hit;
    input [3:0] addr;
    input [3:0] off;
    input wr;
    begin
      wr_hit = wr && (addr == off);
    end
  endfunction

  // picks one byte of a sixteen-bit view for the read mux
  function [7:0] byte_pick;
    input [15:0] value;
    input high;
    begin
      byte_pick = high ? value[15:8] : value[7:0];
    end
  endfunction

  // next value of a plain read/write byte register
  function [7:0] byte_next;
    input [7:0] cur;
    input hit;
    input [7:0] wdata;
    begin
      byte_next = hit ? wdata : cur;
    end
  endfunction

  // write strobes; an unmapped index hits none, so such writes vanish
  assign wr_enable_high = wr_hit(reg_addr, `PDL_OFF_ENABLE_HIGH, reg_wr);
  assign wr_enable_low = wr_hit(reg_addr, `PDL_OFF_ENABLE_LOW, reg_wr);
  assign wr_level_high = wr_hit(reg_addr, `PDL_OFF_LEVEL_HIGH, reg_wr);
  assign wr_level_low = wr_hit(reg_addr, `PDL_OFF_LEVEL_LOW, reg_wr);
  assign wr_staged_high = wr_hit(reg_addr, `PDL_OFF_STAGED_HIGH, reg_wr);
  assign wr_staged_low = wr_hit(reg_addr, `PDL_OFF_STAGED_LOW, reg_wr);
  assign wr_trig_select = wr_hit(reg_addr, `PDL_OFF_TRIG_SELECT, reg_wr);

  // next values: a byte changes only on its own write strobe
  assign next_enable_high_d = byte_next(next_enable_high_q, wr_enable_high, reg_wdata);
  assign next_enable_low_d = byte_next(next_enable_low_q, wr_enable_low, reg_wdata);
  assign staged_level_high_d = byte_next(staged_level_high_q, wr_staged_high, reg_wdata);
  assign staged_level_low_d = byte_next(staged_level_low_q, wr_staged_low, reg_wdata);
  assign trig_select_d = byte_next(trig_select_q, wr_trig_select, reg_wdata); // [RL8]

  // enable byte for outputs 15..8; every bit reads back as written
  always @(posedge core_clk) begin
    if (rst) begin
      next_enable_high_q <= `PDL_RST_ENABLE; // [RL7]
    end else begin
      next_enable_high_q <= next_enable_high_d; // [RL1] [RL7]
    end
  end

  // enable byte for outputs 7..0
  always @(posedge core_clk) begin
    if (rst) begin
      next_enable_low_q <= `PDL_RST_ENABLE; // [RL7]
    end else begin
      next_enable_low_q <= next_enable_low_d; // [RL1] [RL7]
    end
  end

  // staged byte for outputs 15..8; only enabled bits ever use it
  always @(posedge core_clk) begin
    if (rst) begin
      staged_level_high_q <= `PDL_RST_STAGED;
    end else begin
      staged_level_high_q <= staged_level_high_d;
    end
  end

  // staged byte for outputs 7..0
  always @(posedge core_clk) begin
    if (rst) begin
      staged_level_low_q <= `PDL_RST_STAGED;
    end else begin
      staged_level_low_q <= staged_level_low_d;
    end
  end

  // trigger choice, two bits per group
  always @(posedge core_clk) begin
    if (rst) begin
      trig_select_q <= `PDL_RST_TRIG_SELECT;
    end else begin
      trig_select_q <= trig_select_d; // [RL8]
    end
  end

  // sixteen-bit views; high byte first so bit i belongs to output i
  assign pulse_bit_enable = {next_enable_high_q, next_enable_low_q}; // [RL1]
  assign staged_level = {staged_level_high_q, staged_level_low_q};

  // byte-wide write mask into the output level register; the groups
  // drop the enabled bits from it, which makes those bits read-only
  assign cpu_wr_mask = {{8{wr_level_high}}, {8{wr_level_low}}};
  assign cpu_wr_data = {reg_wdata, reg_wdata};

  // four independent groups, each with its own trigger choice
  genvar g;
  generate
    for (g = 0; g < `PDL_NUM_GROUPS; g = g + 1) begin : grp
      pdl_group u_group ( // [RL9] [RL4]
        .core_clk(core_clk),
        .rst(rst),
        .trig_pulse(trig_pulse),
        .trig_sel(trig_select_q[2*g+1:2*g]), // [RL8]
        .enable(pulse_bit_enable[4*g+3:4*g]),
        .staged(staged_level[4*g+3:4*g]),
        .cpu_wr_mask(cpu_wr_mask[4*g+3:4*g]),
        .cpu_wr_data(cpu_wr_data[4*g+3:4*g]),
        .level(level[4*g+3:4*g])
      );
    end
  endgenerate

  // pins come straight from the level flops, no extra stage
  assign pulse_out = level; // [RL10]

  // read mux, data registered for the following cycle
  always @* begin
    case (reg_addr)
      `PDL_OFF_ENABLE_HIGH: begin
        rdata_d = next_enable_high_q; // [RL7]
      end
      `PDL_OFF_ENABLE_LOW: begin
        rdata_d = next_enable_low_q; // [RL7]
      end
      `PDL_OFF_LEVEL_HIGH: begin
        rdata_d = byte_pick(level, 1'b1); // [RL5]
      end
      `PDL_OFF_LEVEL_LOW: begin
        rdata_d = byte_pick(level, 1'b0); // [RL5]
      end
      `PDL_OFF_STAGED_HIGH: begin
        rdata_d = staged_level_high_q;
      end
      `PDL_OFF_STAGED_LOW: begin
        rdata_d = staged_level_low_q;
      end
      `PDL_OFF_TRIG_SELECT: begin
        rdata_d = trig_select_q;
      end
      default: begin
        rdata_d = `PDL_UNMAPPED_READ;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe; zero otherwise,
  // so a stale byte never lingers on the bus
  always @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= `PDL_RST_RDATA;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= `PDL_RST_RDATA;
    end
  end

  assign reg_rdata = rdata_q;
endmodule

//--- pdl_timer_model.sv
module pdl_timer_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] fire,
  output logic [3:0] trig_pulse
);
  timeunit 1ns; timeprecision 1ps;
  // one-cycle compare pulses, quiet in reset like a halted timer
  always @(posedge core_clk) trig_pulse <= rst ? 4'h0 : fire;
endmodule

//--- pdl_top_monitor.sv
module pdl_mon (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [3:0] trig_pulse,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] pulse_out
);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // no write and no trigger means levels sit still
  wire idle = !reg_wr && !trig_pulse;
  wire wh = reg_wr && reg_addr == 4'h2 && !trig_pulse;
  wire wl = reg_wr && reg_addr == 4'h3 && !trig_pulse;
  rd_idle_a: assert property (!reg_rd |=> !reg_rdata) else $error("rd");
  lvl_hold_a: assert property (idle |=> $stable(pulse_out)) else $error("hold");
  wr_high_a: assert property (wh |=> $stable(pulse_out[7:0])) else $error("wh");
  wr_low_a: assert property (wl |=> $stable(pulse_out[15:8])) else $error("wl");
  rd_high_a:
    assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata == $past(pulse_out[15:8]))
    else $error("rh");
  rd_low_a:
    assert property (reg_rd && reg_addr == 4'h3 |=> reg_rdata == $past(pulse_out[7:0]))
    else $error("rl");
  rst_lvl_a: assert property (disable iff (1'b0) rst |=> !pulse_out) else $error("r");
  rst_rd_a: assert property (disable iff (1'b0) rst |=> !reg_rdata) else $error("r");
  cover property (|trig_pulse && |pulse_out);
  cover property (wh ##1 reg_rd);
  cover property (reg_wr ##1 reg_wr);
endmodule
bind pdl_top pdl_mon u_mon (.core_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .trig_pulse,
  .reg_rdata, .pulse_out);

//--- pdl_top_tb.sv
module pdl_top_tb;
  timeunit 1ns; timeprecision 1ps;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_q;
  logic [3:0] reg_addr = 4'h0, fire = 4'h0, trig_pulse;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, exp_rd, rf [16];
  logic [15:0] pulse_out, lv;
  int n_errors = 0, checked = 0, cyc = 0, seed = 32'h3acf, op;
  pdl_top dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .trig_pulse, .pulse_out);
  pdl_timer_model tmr (.core_clk, .rst, .fire, .trig_pulse);
  initial forever #2 core_clk = ~core_clk;
  task chk(input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t %h %h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // enabled bits take staged data on their group's trigger, others take cpu writes
  function automatic logic [15:0] lv_next();
    logic [15:0] n = lv;
    for (int i = 0; i < 16; i++)
      if (rf[i < 8][i % 8]) begin
        if (trig_pulse[rf[6][i / 4 * 2 +: 2]]) n[i] = rf[4 + (i < 8)][i % 8];
      end else if (reg_wr && reg_addr == 2 + (i < 8)) n[i] = reg_wdata[i % 8];
    return n;
  endfunction
  // reference registers on the design's edge; old enables rule a same-edge trigger
  always @(posedge core_clk) begin
    rd_q <= reg_rd && !rst;
    exp_rd <= reg_addr == 2 ? lv[15:8] : reg_addr == 3 ? lv[7:0] : rf[reg_addr];
    if (rst) begin
      lv <= '0;
      rf <= '{default: 8'h00};
    end else begin
      lv <= lv_next();
      if (reg_wr && reg_addr < 7) rf[reg_addr] <= reg_wdata;
    end
    if (++cyc > 4000) begin
      n_errors++;
      stop_test;
    end
  end
  // compare mid-cycle, once the edge's updates have landed
  always @(negedge core_clk) if (!rst) begin
    chk(pulse_out, lv);
    chk(reg_rdata, rd_q ? exp_rd : 8'h00);
  end
  // all sixteen indices read first, then random traffic with a mid-run reset
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 0; k < 3000; k++) begin
      @(posedge core_clk);
      op = $random(seed);
      rst <= k == 1500;
      reg_wr <= k > 15 && op[0];
      reg_rd <= k < 16 || op[1] && !op[0];
      reg_addr <= k < 16 ? 4'(k) : op[5:2] & (op[6] ? 4'hf : 4'h7);
      reg_wdata <= op[14:7];
      fire <= op[18:15] & op[22:19];
    end
    stop_test;
  end
endmodule
